// ### verilog/pma_consts.vh
/*
 * pma_consts.vh: register offsets, field positions, reset values and
 * sizes for the alarm and interface-select housekeeping block.
 * Assumes it is included by bare name from the design files.
 */
`ifndef PMA_CONSTS_VH
`define PMA_CONSTS_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define PMA_OFS_SYSCTL 8'h00
`define PMA_OFS_ALMSTAT 8'h04
`define PMA_OFS_IRQSTAT 8'h08
`define PMA_OFS_IRQMASK 8'h0C
`define PMA_OFS_IFSTAT 8'h10
`define PMA_OFS_CH0 8'h20
`define PMA_OFS_CH3 8'h2C

// ------------------------------------------------------------
// system control fields
// ------------------------------------------------------------
`define PMA_SC_CG_EN 0
`define PMA_SC_CG_LATCH 1
`define PMA_SC_GUARD_SRC 2
`define PMA_SC_CLAMP_SRC 3
`define PMA_SC_THR_LSB 8
`define PMA_SC_THR_W 8
`define PMA_SYSCTL_RST 32'h0000_8200

// ------------------------------------------------------------
// channel register fields
// ------------------------------------------------------------
`define PMA_CH_LOW_SENSE 0
`define PMA_CH_CLEAR 6
`define PMA_CH_W 7

// ------------------------------------------------------------
// alarm status layout: temp bits, then four bits per channel
// ------------------------------------------------------------
`define PMA_AS_TEMP_LAT 0
`define PMA_AS_TEMP_LIVE 1
`define PMA_AS_CH_BASE 2
`define PMA_AS_CH_STRIDE 4

// ------------------------------------------------------------
// interrupt events
// ------------------------------------------------------------
`define PMA_IRQ_TEMP 0
`define PMA_IRQ_GUARD 1
`define PMA_IRQ_CLAMP 2
`define PMA_IRQ_W 3
`define PMA_IRQMASK_RST 3'h0

`define PMA_NCH 4
`define PMA_SYNC_STAGES 2

`endif

// ### verilog/pma_sync.v
/*
 * pma_sync.v: multi-bit two-flop synchroniser for levels from outside
 * the clock domain. Bits are treated as independent levels; no word
 * coherence is promised across bits.
 */
`timescale 1ns/1ps
`default_nettype none

module pma_sync #(
    parameter WIDTH = 1
) (
    input wire clock,
    input wire rst_b,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_r;

    // first stage is read only by the second
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule // pma_sync

`default_nettype wire

// ### verilog/pma_alarm_top.v
/*
 * pma_alarm_top.v: digital housekeeping of a quad measurement unit:
 * temperature alarm, guard/clamp alarm, alarm status, interface strap
 * and per-channel low-sense select, with an APB register slave.
 * Assumes fault inputs and the strap are asynchronous levels, and the
 * temperature code comes from on-chip logic on the same clock.
 */
// Functional notes
// - low level on reset clears all state but the threshold, which loads 130, at once, without waiting for a clock.
// - temperature alarm pin pulls low and stays latched once over threshold.
// - status holds latched and live temperature flags.
// - writing clear bit 6 of any channel register releases temp alarm.
// - guard/clamp pin off after reset; control enables it and picks latched mode.
// - host picks guard faults, clamp faults or both as pin sources.
// - each channel has latched and live flags in the status word.
// - strap low selects serial interface, high differential; low when undriven.
// - differential mode turns comparator pins into interface pins.
// - low sense shared by default; each channel may use its guard pin.
`timescale 1ns/1ps
`default_nettype none
`include "pma_consts.vh"

module pma_alarm_top (
    input wire clock,
    input wire rst_b,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // analog-side levels
    input wire [7:0] temp_code,
    input wire [3:0] guard_fault,
    input wire [3:0] clamp_fault,
    input wire iface_sel_strap,
    // open-drain alarm pins: output value and enable
    output reg over_temp_alarm_n_o,
    output reg over_temp_alarm_n_oe,
    output reg guard_clamp_alarm_n_o,
    output reg guard_clamp_alarm_n_oe,
    // interface and sense routing
    output reg diff_iface_mode,
    output reg comparator_pins_diff,
    output reg [3:0] guard_in_or_low_sense,
    output reg irq
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    reg [31:0] sysctl_r;
    reg [`PMA_CH_W-1:0] ch_r [0:3];
    reg temp_lat_r;
    reg [3:0] guard_lat_r;
    reg [3:0] clamp_lat_r;
    reg [`PMA_IRQ_W-1:0] irq_stat_r;
    reg [`PMA_IRQ_W-1:0] irq_mask_r;
    reg temp_live_d_r;
    reg guard_any_d_r;
    reg clamp_any_d_r;
    wire [3:0] guard_s;
    wire [3:0] clamp_s;
    wire strap_s;
    // one loop index per process, so no variable has two drivers
    integer i;
    integer j;
    integer k;
    integer m;

    // ------------------------------------------------------------
    // synchronise outside levels
    // ------------------------------------------------------------
    // faults and strap are slow levels, so per-bit sync is enough;
    // a fault shorter than one clock may be missed by the flags
    pma_sync #(.WIDTH(9)) u_sync (
        .clock(clock),
        .rst_b(rst_b),
        .async_in({iface_sel_strap, clamp_fault, guard_fault}),
        .sync_out({strap_s, clamp_s, guard_s})
    );

    // channel register index from a byte address, 4 means none
    function [2:0] ch_index;
        input [7:0] a;
        begin
            if (a >= `PMA_OFS_CH0 && a <= `PMA_OFS_CH3 && a[1:0] == 2'b00)
                ch_index = {1'b0, a[3:2]};
            else
                ch_index = 3'd4;
        end
    endfunction

    // bit position of flag f of channel c in the alarm status word
    function integer as_pos;
        input integer c;
        input integer f;
        begin
            as_pos = `PMA_AS_CH_BASE + `PMA_AS_CH_STRIDE * c + f;
        end
    endfunction

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire acc = psel && penable && pready;
    wire wr = acc && pwrite;
    wire [2:0] chi = ch_index(paddr);
    // one select per register, one for all four channel registers, shared by the clear and error logic
    wire sel_sysctl = (paddr == `PMA_OFS_SYSCTL);
    wire sel_almstat = (paddr == `PMA_OFS_ALMSTAT);
    wire sel_irqstat = (paddr == `PMA_OFS_IRQSTAT);
    wire sel_irqmask = (paddr == `PMA_OFS_IRQMASK);
    wire sel_ifstat = (paddr == `PMA_OFS_IFSTAT);
    wire sel_ch = (chi != 3'd4);
    wire hit = sel_sysctl || sel_almstat || sel_irqstat || sel_irqmask || sel_ifstat || sel_ch;
    // clear strobe: bit 6 written to any channel register
    wire temp_clr = wr && sel_ch && pwdata[`PMA_CH_CLEAR];
    wire alm_wr = wr && sel_almstat;

    // ------------------------------------------------------------
    // live conditions
    // ------------------------------------------------------------
    // compare is strict: a code equal to the limit is not yet hot
    wire [7:0] thr = sysctl_r[`PMA_SC_THR_LSB +: `PMA_SC_THR_W];
    wire temp_live = (temp_code > thr);
    wire guard_any = |guard_s;
    wire clamp_any = |clamp_s;
    // source selection for the shared pin
    wire cg_live = (sysctl_r[`PMA_SC_GUARD_SRC] && guard_any) ||
                   (sysctl_r[`PMA_SC_CLAMP_SRC] && clamp_any);
    wire cg_held = (sysctl_r[`PMA_SC_GUARD_SRC] && (|guard_lat_r)) ||
                   (sysctl_r[`PMA_SC_CLAMP_SRC] && (|clamp_lat_r));
    wire cg_assert = sysctl_r[`PMA_SC_CG_EN] &&
                     (sysctl_r[`PMA_SC_CG_LATCH] ? cg_held : cg_live);

    // alarm status word: temp flags then per channel guard/clamp pairs
    // channel live bits show the synchronised faults, two clocks behind the pins
    reg [31:0] alm_word;
    always @* begin
        alm_word = 32'h0000_0000;
        alm_word[`PMA_AS_TEMP_LAT] = temp_lat_r;
        alm_word[`PMA_AS_TEMP_LIVE] = temp_live;
        for (i = 0; i < `PMA_NCH; i = i + 1) begin
            alm_word[as_pos(i, 0)] = guard_lat_r[i];
            alm_word[as_pos(i, 1)] = guard_s[i];
            alm_word[as_pos(i, 2)] = clamp_lat_r[i];
            alm_word[as_pos(i, 3)] = clamp_s[i];
        end
    end

    // read mux; unmapped addresses read zero and raise pslverr
    // status is taken one cycle before pready, so it is one clock old
    reg [31:0] rd_nxt;
    always @* begin
        rd_nxt = 32'h0000_0000;
        if (paddr == `PMA_OFS_SYSCTL)
            rd_nxt = sysctl_r;
        else if (paddr == `PMA_OFS_ALMSTAT)
            rd_nxt = alm_word;
        else if (paddr == `PMA_OFS_IRQSTAT)
            rd_nxt = {29'h0, irq_stat_r};
        else if (paddr == `PMA_OFS_IRQMASK)
            rd_nxt = {29'h0, irq_mask_r};
        else if (paddr == `PMA_OFS_IFSTAT)
            rd_nxt = {30'h0, comparator_pins_diff, diff_iface_mode};
        else if (chi != 3'd4)
            rd_nxt = {25'h0, ch_r[chi[1:0]]};
    end

    // ------------------------------------------------------------
    // apb handshake: one wait state so read data leave a flop
    // ------------------------------------------------------------
    // the wait state costs a cycle per transfer but keeps prdata off
    // the live status bits, which could otherwise move mid access
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
            pslverr <= !hit;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    // unused control bits read back as zero, so nothing is parked there
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sysctl_r <= `PMA_SYSCTL_RST; // pin disabled, threshold 130
            irq_mask_r <= `PMA_IRQMASK_RST;
            for (j = 0; j < `PMA_NCH; j = j + 1)
                ch_r[j] <= {`PMA_CH_W{1'b0}}; // shared low sense
        end else if (wr) begin
            if (paddr == `PMA_OFS_SYSCTL)
                sysctl_r <= {16'h0, pwdata[15:8], 4'h0, pwdata[3:0]};
            if (paddr == `PMA_OFS_IRQMASK)
                irq_mask_r <= pwdata[`PMA_IRQ_W-1:0];
            if (chi != 3'd4) // clear bit is a strobe, not stored
                ch_r[chi[1:0]] <= {1'b0, pwdata[5:0]};
        end
    end

    // ------------------------------------------------------------
    // latched alarm flags; set wins over clear
    // ------------------------------------------------------------
    // a clear that meets a live fault is lost on purpose: software
    // sees the flag again rather than miss a fault still present
    wire temp_lat_nxt = temp_live || (temp_lat_r && !temp_clr);
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            temp_lat_r <= 1'b0;
            guard_lat_r <= 4'h0;
            clamp_lat_r <= 4'h0;
        end else begin
            temp_lat_r <= temp_lat_nxt;
            for (k = 0; k < `PMA_NCH; k = k + 1) begin
                guard_lat_r[k] <= guard_s[k] || (guard_lat_r[k] &&
                    !(alm_wr && pwdata[as_pos(k, 0)]));
                clamp_lat_r[k] <= clamp_s[k] || (clamp_lat_r[k] &&
                    !(alm_wr && pwdata[as_pos(k, 2)]));
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt: rising edges of conditions, write one to clear
    // ------------------------------------------------------------
    wire [`PMA_IRQ_W-1:0] ev = {clamp_any && !clamp_any_d_r,
                               guard_any && !guard_any_d_r,
                               temp_live && !temp_live_d_r};
    wire [`PMA_IRQ_W-1:0] iclr = (wr && sel_irqstat) ?
                                 pwdata[`PMA_IRQ_W-1:0] : {`PMA_IRQ_W{1'b0}};
    // next status worked out once so flag and pin never disagree
    wire [`PMA_IRQ_W-1:0] irq_stat_nxt = ev | (irq_stat_r & ~iclr);
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            temp_live_d_r <= 1'b0;
            guard_any_d_r <= 1'b0;
            clamp_any_d_r <= 1'b0;
            irq_stat_r <= {`PMA_IRQ_W{1'b0}};
            irq <= 1'b0;
        end else begin
            temp_live_d_r <= temp_live;
            guard_any_d_r <= guard_any;
            clamp_any_d_r <= clamp_any;
            irq_stat_r <= irq_stat_nxt;
            irq <= |(irq_stat_nxt & irq_mask_r);
        end
    end

    // ------------------------------------------------------------
    // pins: open drain pulls low when enabled
    // ------------------------------------------------------------
    // the drive value stays low and only the enables move, so a pin
    // is never pushed high against the board pull-up
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            over_temp_alarm_n_o <= 1'b0;
            over_temp_alarm_n_oe <= 1'b0;
            guard_clamp_alarm_n_o <= 1'b0;
            guard_clamp_alarm_n_oe <= 1'b0;
        end else begin
            over_temp_alarm_n_o <= 1'b0;
            guard_clamp_alarm_n_o <= 1'b0;
            // flag already holds the latch, so pin follows it
            over_temp_alarm_n_oe <= temp_lat_nxt;
            guard_clamp_alarm_n_oe <= cg_assert;
        end
    end

    // ------------------------------------------------------------
    // interface strap and per-channel sense routing
    // ------------------------------------------------------------
    // the strap is meant to be fixed at power-up; a change while
    // running is followed after the sync delay with no further guard
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            diff_iface_mode <= 1'b0;
            comparator_pins_diff <= 1'b0;
            guard_in_or_low_sense <= 4'h0;
        end else begin
            diff_iface_mode <= strap_s; // undriven strap reads low
            comparator_pins_diff <= strap_s;
            for (m = 0; m < `PMA_NCH; m = m + 1)
                guard_in_or_low_sense[m] <= ch_r[m][`PMA_CH_LOW_SENSE];
        end
    end

endmodule // pma_alarm_top

`default_nettype wire

// ### verif/pma_alarm_props.sv
/* pma_alarm_props.sv: port assertions for the alarm block.
 * Assumes binding onto pma_alarm_top; control bits are shadowed from APB writes. */
`timescale 1ns/1ps
`default_nettype none
`include "pma_consts.vh"
module pma_alarm_props (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] temp_code,
    input wire logic [3:0] guard_fault,
    input wire logic iface_sel_strap,
    input wire logic over_temp_alarm_n_oe,
    input wire logic guard_clamp_alarm_n_oe,
    input wire logic diff_iface_mode,
    input wire logic comparator_pins_diff
);
    // ----------
    // control shadow
    // ----------
    logic [31:0] ctl_r;
    logic [1:0] off_r;
    wire logic wr_done = psel && penable && pready && pwrite && !pslverr;
    wire logic ch_hit = paddr >= `PMA_OFS_CH0 && paddr <= `PMA_OFS_CH3;
    wire logic clr_hit = wr_done && ch_hit && pwdata[`PMA_CH_CLEAR];
    wire logic hot = temp_code > ctl_r[15:8];
    // off_r saturates, giving the pin a short grace after disable
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ctl_r <= `PMA_SYSCTL_RST;
            off_r <= 2'd0;
        end else begin
            if (wr_done && paddr == `PMA_OFS_SYSCTL) begin
                ctl_r <= pwdata;
            end
            off_r <= ctl_r[0] ? 2'd0 : off_r + {1'b0, off_r != 2'd3};
        end
    end
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    // ----------
    // properties
    // ----------
    temp_set_a: assert property (hot |=> over_temp_alarm_n_oe)
        else $error("temp pin not pulled when over limit");
    temp_hold_a: assert property ($fell(over_temp_alarm_n_oe) |->
        $past(clr_hit, 1) || $past(clr_hit, 2) || $past(clr_hit, 3))
        else $error("temp pin released without clear");
    cg_off_a: assert property (off_r == 2'd3 |-> !guard_clamp_alarm_n_oe)
        else $error("guard pin pulled while disabled");
    gc_follow_a: assert property (
        (ctl_r[0] && !ctl_r[1] && ctl_r[2] && |guard_fault)[*4] |=> guard_clamp_alarm_n_oe)
        else $error("guard fault not on pin");
    diff_pins_a: assert property ($stable(diff_iface_mode) |->
        comparator_pins_diff == diff_iface_mode)
        else $error("comparator pins disagree with mode");
    strap_hi_a: assert property (iface_sel_strap[*4] |=> diff_iface_mode)
        else $error("strap high but serial mode");
    strap_lo_a: assert property ((!iface_sel_strap)[*4] |=> !diff_iface_mode)
        else $error("strap low but differential mode");
    bus_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("no answer after one wait state");
    cover property (clr_hit);
    cover property ($rose(diff_iface_mode));
    cover property ($fell(guard_clamp_alarm_n_oe) && ctl_r[1]);
endmodule // pma_alarm_props
bind pma_alarm_top pma_alarm_props chk (.clock, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .pslverr, .temp_code, .guard_fault, .iface_sel_strap,
    .over_temp_alarm_n_oe, .guard_clamp_alarm_n_oe, .diff_iface_mode, .comparator_pins_diff);
`default_nettype wire

// ### verif/pma_host_model.sv
/* pma_host_model.sv: host controller on APB plus board pull-ups on both alarm pins.
 * Assumes a single clock; transfers are started only after reset. */
`timescale 1ns/1ps
`default_nettype none
module pma_host_model (
    input wire logic clock,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic ot_oe,
    input wire logic cg_oe,
    output logic temp_pin,
    output logic cg_pin
);
    // pull-ups win whenever the device lets go
    assign temp_pin = ot_oe ? 1'b0 : 1'b1;
    assign cg_pin = cg_oe ? 1'b0 : 1'b1;
    // idle bus from time zero
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    // request held until pready is seen; stale data inverted on release
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask
endmodule // pma_host_model
`default_nettype wire

// ### verif/pma_bench.sv
/* pma_bench.sv: self-checking bench for the alarm and interface-select block.
 * Assumes the host model and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "pma_consts.vh"
`define CHK(nm, x, g) begin samples_checked++; if ((g) !== (x)) begin n_fail++; \
    $display("Error %s expected %h got %h", nm, x, g); end end
module pma_alarm_and_interface_select_bench;
    logic clock, rst_b, iface_sel_strap, e;
    logic [7:0] temp_code;
    logic [3:0] guard_fault, clamp_fault;
    logic [31:0] r;
    wire psel, penable, pwrite, pready, pslverr, irq, temp_pin, cg_pin;
    wire over_temp_alarm_n_o, over_temp_alarm_n_oe, guard_clamp_alarm_n_o;
    wire guard_clamp_alarm_n_oe, diff_iface_mode, comparator_pins_diff;
    wire [7:0] paddr;
    wire [31:0] pwdata, prdata;
    wire [3:0] guard_in_or_low_sense;
    wire [8:0] pins = {over_temp_alarm_n_oe, guard_clamp_alarm_n_oe, diff_iface_mode,
        comparator_pins_diff, guard_in_or_low_sense, irq};
    int n_fail = 0;
    int samples_checked = 0;
    pma_alarm_top dut (.clock, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .temp_code, .guard_fault, .clamp_fault, .iface_sel_strap,
        .over_temp_alarm_n_o, .over_temp_alarm_n_oe, .guard_clamp_alarm_n_o,
        .guard_clamp_alarm_n_oe, .diff_iface_mode, .comparator_pins_diff,
        .guard_in_or_low_sense, .irq);
    pma_host_model host (.clock, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .ot_oe(over_temp_alarm_n_oe), .cg_oe(guard_clamp_alarm_n_oe),
        .temp_pin, .cg_pin);
    // 20 MHz clock
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // ----------
    // helpers
    // ----------
    task cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, r, e);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] x);
        host.xfer(1'b0, a, 32'h0, r, e);
        `CHK("read", {1'b0, x}, {e, r})
    endtask
    // analog-side levels change at an edge, then settle n cycles
    task set_in(input logic [7:0] t, input logic [3:0] g, input logic [3:0] c,
        input logic s, input int n);
        @(posedge clock);
        temp_code <= t;
        guard_fault <= g;
        clamp_fault <= c;
        iface_sel_strap <= s;
        cyc(n);
    endtask
    task results;
        if (n_fail == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // the whole run is a few hundred cycles
    initial begin
        #400000;
        n_fail++;
        results;
    end
    // ----------
    // tests
    // ----------
    initial begin
        {rst_b, temp_code, guard_fault, clamp_fault, iface_sel_strap} = '0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        cyc(1);
        `CHK("reset pins", 9'h000, pins)
        rd(`PMA_OFS_SYSCTL, 32'h0000_8200);
        rd(`PMA_OFS_IFSTAT, 32'h0);
        wr(8'h40, 32'hFFFF_FFFF);
        rd(`PMA_OFS_ALMSTAT, 32'h0);
        host.xfer(1'b0, 8'h40, 32'h0, r, e);
        `CHK("unmapped", 33'h1_0000_0000, {e, r})
        for (int i = 0; i < 4; i++) begin
            wr(8'h20 + 8'(4 * i), 32'h0000_007F);
            rd(8'h20 + 8'(4 * i), 32'h0000_003F);
            `CHK("low sense", 4'(1 << i), guard_in_or_low_sense)
            wr(8'h20 + 8'(4 * i), 32'h0);
        end
        wr(`PMA_OFS_IRQMASK, 32'h1);
        set_in(8'd130, 4'h0, 4'h0, 1'b0, 3);
        `CHK("temp at limit", 1'b1, temp_pin)
        set_in(8'd131, 4'h0, 4'h0, 1'b0, 2);
        `CHK("temp over", 2'b01, {temp_pin, irq})
        set_in(8'd20, 4'h0, 4'h0, 1'b0, 2);
        rd(`PMA_OFS_ALMSTAT, 32'h1);
        wr(`PMA_OFS_IRQSTAT, 32'h1);
        wr(`PMA_OFS_CH3, 32'h0000_0040);
        cyc(2);
        `CHK("temp clear", 2'b10, {temp_pin, irq})
        wr(`PMA_OFS_SYSCTL, 32'h0000_6400);
        set_in(8'd101, 4'h0, 4'h0, 1'b0, 2);
        wr(`PMA_OFS_CH0, 32'h0000_0040);
        cyc(2);
        `CHK("user limit", 1'b0, temp_pin)
        set_in(8'd20, 4'h0, 4'h0, 1'b0, 1);
        wr(`PMA_OFS_CH0, 32'h0000_0040);
        cyc(2);
        `CHK("temp clear", 1'b1, temp_pin)
        for (int s = 1; s < 4; s++) begin
            for (int f = 0; f < 2; f++) begin
                wr(`PMA_OFS_SYSCTL, 32'h0000_8201 | 32'(s << 2));
                set_in(8'd20, f ? 4'h0 : 4'h2, f ? 4'h2 : 4'h0, 1'b0, 4);
                `CHK("cg source", 1'(s >> f), guard_clamp_alarm_n_oe)
                rd(`PMA_OFS_ALMSTAT, f ? 32'h0000_0300 : 32'h0000_00C0);
                set_in(8'd20, 4'h0, 4'h0, 1'b0, 4);
                `CHK("cg follow", 1'b1, cg_pin)
                rd(`PMA_OFS_ALMSTAT, f ? 32'h0000_0100 : 32'h0000_0040);
                wr(`PMA_OFS_ALMSTAT, 32'h0000_0140);
            end
        end
        rd(`PMA_OFS_IRQSTAT, 32'h0000_0007);
        wr(`PMA_OFS_IRQSTAT, 32'h0000_0007);
        rd(`PMA_OFS_IRQSTAT, 32'h0000_0000);
        `CHK("irq clear", 1'b0, irq)
        wr(`PMA_OFS_SYSCTL, 32'h0000_820F);
        set_in(8'd20, 4'h8, 4'h0, 1'b0, 5);
        set_in(8'd20, 4'h0, 4'h0, 1'b0, 5);
        `CHK("cg latched", 1'b0, cg_pin)
        rd(`PMA_OFS_ALMSTAT, 32'h0000_4000);
        wr(`PMA_OFS_SYSCTL, 32'h0000_820E);
        cyc(3);
        `CHK("cg disabled", 1'b1, cg_pin)
        wr(`PMA_OFS_ALMSTAT, 32'h0000_4000);
        rd(`PMA_OFS_ALMSTAT, 32'h0);
        set_in(8'd20, 4'h0, 4'h0, 1'b1, 5);
        `CHK("diff mode", 2'b11, {diff_iface_mode, comparator_pins_diff})
        rd(`PMA_OFS_IFSTAT, 32'h3);
        set_in(8'd200, 4'h0, 4'h0, 1'b0, 5);
        `CHK("serial mode", 3'b100, pins[8:6])
        `CHK("drive level", 2'b00, {over_temp_alarm_n_o, guard_clamp_alarm_n_o})
        @(posedge clock) rst_b <= 1'b0;
        set_in(8'd20, 4'h0, 4'h0, 1'b0, 2);
        `CHK("mid reset", 9'h000, pins)
        @(posedge clock) rst_b <= 1'b1;
        rd(`PMA_OFS_ALMSTAT, 32'h0);
        rd(`PMA_OFS_SYSCTL, 32'h0000_8200);
        results;
    end
endmodule // pma_alarm_and_interface_select_bench
`default_nettype wire
